// ==== bench/ldsc_src_model.sv ====
// Model of the external sources: phase inputs, PD ticks, calibration, tuning
`timescale 1ns/1ps
module ldsc_src_model #(
  parameter int CAL_LEN = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick_en,
  input wire logic cal_go,
  input wire logic tog_sync,
  input wire logic tog_ref,
  input wire logic vtune_set,
  output logic sync_out,
  output logic refreq_out,
  output logic half_tick_out,
  output logic cal_start_out,
  output logic cal_done_out,
  output logic vtune_ok_out
);
  int cnt;
  logic ph;
  // Calibration is slow on purpose, so a stale lock would be visible
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {sync_out, refreq_out, half_tick_out, ph} <= '0;
      {cal_start_out, cal_done_out, vtune_ok_out} <= '0;
      cnt <= 0;
    end else begin
      half_tick_out <= tick_en && !ph;
      ph <= tick_en ? !ph : 1'b0;
      cal_start_out <= cal_go;
      cal_done_out <= (cnt == 1);
      cnt <= cal_go ? CAL_LEN : (cnt > 0 ? cnt - 1 : 0);
      if (tog_sync) sync_out <= !sync_out;
      if (tog_ref) refreq_out <= !refreq_out;
      vtune_ok_out <= vtune_set;
    end
  end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the lock-detect and sync-input block
`timescale 1ns/1ps
module tb
  import ldsc_pkg::*;
;
  logic clk = 0, rst = 1;
  logic [9:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, bias;
  logic tick_en = 0, cal_go = 0, tog_s = 0, tog_r = 0, vt_set = 0;
  logic s_in, r_in, tick, c_start, c_done, vt_ok;
  logic s_lvds, r_lvds, filt, hyst, bias_bad, s_ev, r_ev, lock, irq;
  int miscompares = 0, cmp_count = 0, s_evs = 0, r_evs = 0, n;
  logic [31:0] d;
  logic [1:0] rs;
  logic [15:0] cfg;
  localparam int NR = 7;
  logic [7:0] t_idx [NR] = '{8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h51, 8'h60};
  logic [15:0] t_wd [NR] = '{16'h8001, 16'h0000, 16'h0005, 16'h00A8,
    16'h00AF, 16'h0000, 16'hFFFF};
  logic [1:0] t_rs [NR] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
  logic [15:0] r_val [5] = '{LDSC_RST_SYNC_CFG, LDSC_RST_LD_SEL,
    LDSC_RST_LOCK_INDICATOR_DELAY, LDSC_RST_FIXED, LDSC_RST_BUF_CTL};

  always #12.5 clk = ~clk;

  ldsc_top dut_u (.CLK_IN(clk), .RST_IN(rst),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready), .SYNC_IN(s_in), .REFREQ_IN(r_in),
    .PD_HALF_TICK_IN(tick), .CAL_START_IN(c_start), .CAL_DONE_IN(c_done),
    .VTUNE_OK_IN(vt_ok), .SYNC_LVDS_OUT(s_lvds), .REFREQ_LVDS_OUT(r_lvds),
    .LVDS_FILTER_OUT(filt), .HIGH_HYST_OUT(hyst), .BIAS_LEVEL_OUT(bias),
    .BIAS_INVALID_OUT(bias_bad), .SYNC_EVENT_OUT(s_ev),
    .REFREQ_EVENT_OUT(r_ev), .LOCK_OUT(lock), .IRQ_OUT(irq));

  ldsc_src_model src_u (.clk(clk), .rst(rst), .tick_en(tick_en),
    .cal_go(cal_go), .tog_sync(tog_s), .tog_ref(tog_r), .vtune_set(vt_set),
    .sync_out(s_in), .refreq_out(r_in), .half_tick_out(tick),
    .cal_start_out(c_start), .cal_done_out(c_done), .vtune_ok_out(vt_ok));

  // Event pulses are combinational, so count them mid-cycle
  always @(negedge clk) begin
    if (s_ev === 1'b1) s_evs++;
    if (r_ev === 1'b1) r_evs++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic axw(input logic [7:0] idx, input logic [15:0] v,
                     output logic [1:0] r);
    logic a, w, b;
    int k;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, v};
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    k = 0;
    b = 0;
    while (!b && k < 64) begin
      @(negedge clk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      r = bresp;
      @(posedge clk);
      if (a) awvalid <= 0;
      if (w) wvalid <= 0;
      if (b) bready <= 0;
      k++;
    end
    if (!b) chk(32'h0, 32'h1);
  endtask

  task automatic axr(input logic [7:0] idx, output logic [31:0] v,
                     output logic [1:0] r);
    logic a, b;
    int k;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    k = 0;
    b = 0;
    while (!b && k < 64) begin
      @(negedge clk);
      a = arvalid && arready;
      b = rvalid && rready;
      v = rdata;
      r = rresp;
      @(posedge clk);
      if (a) arvalid <= 0;
      if (b) rready <= 0;
      k++;
    end
    if (!b) chk(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] v);
    axw(idx, v, rs);
    chk(rs, LDSC_RESP_OK);
  endtask

  task automatic toggle();
    @(posedge clk);
    tog_s <= 1;
    tog_r <= 1;
    @(posedge clk);
    tog_s <= 0;
    tog_r <= 0;
    repeat (4) @(negedge clk);
  endtask

  // Calibration request, returns in the cycle that calibration ends
  task automatic cal();
    int k;
    @(posedge clk);
    cal_go <= 1;
    @(posedge clk);
    cal_go <= 0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (c_done !== 1'b1 && k < 40);
    if (c_done !== 1'b1) chk(32'h0, 32'h1);
  endtask

  task automatic wait_lock(output int k);
    k = 0;
    while (lock !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    chk(lock, 1'b0);
    chk(irq, 1'b0);
    for (int i = 0; i < 5; i++) begin
      axr(t_idx[i], d, rs);
      chk(d, {16'h0000, r_val[i]});
    end
    // Register table, unmapped index last
    for (int i = 0; i < NR; i++) begin
      axw(t_idx[i], t_wd[i], rs);
      chk(rs, t_rs[i]);
      axr(t_idx[i], d, rs);
      chk(rs, t_rs[i]);
      chk(d, (t_rs[i] == 2'h0) ? {16'h0000, t_wd[i]} : 32'h0);
    end
    // Every format code; bias cycles through the three legal codes
    for (int i = 0; i < 8; i++) begin
      cfg = 16'(16'h8001 | (i << 9) | ((i % 3) << 12)
                | ((i & 1) << 14));
      wr(LDSC_IDX_SYNC_CFG, cfg);
      chk(s_lvds, i[0]);
      chk(r_lvds, i[1]);
      chk(filt, i >= 5);
      chk(hyst, i[0]);
      chk(bias, i % 3);
      chk(bias_bad, 1'b0);
    end
    wr(LDSC_IDX_SYNC_CFG, 16'h8001);
    wr(LDSC_IDX_CTRL, 16'h0000);
    toggle();
    chk(s_evs, 0);
    chk(r_evs, 0);
    wr(LDSC_IDX_CTRL, 16'h0001);
    wr(LDSC_IDX_SYNC_CFG, 16'h0001);
    toggle();
    chk(s_evs, 1);
    chk(r_evs, 1);
    wr(LDSC_IDX_SYNC_CFG, 16'h8001);
    toggle();
    chk(s_evs, 2);
    chk(r_evs, 2);
    wr(LDSC_IDX_CTRL, 16'h0000);
    // Interrupt: masked, unmasked, cleared bit by bit
    chk(irq, 1'b0);
    axr(LDSC_IDX_STATUS, d, rs);
    chk(d & 32'hC, 32'hC);
    wr(LDSC_IDX_MASK, 16'h0004);
    chk(irq, 1'b1);
    wr(LDSC_IDX_STATUS, 16'h0004);
    chk(irq, 1'b0);
    axr(LDSC_IDX_STATUS, d, rs);
    chk(d & 32'hC, 32'h8);
    wr(LDSC_IDX_STATUS, 16'h0008);
    // Lock kind 0 with a delay of three half cycles
    wr(LDSC_IDX_LOCK_INDICATOR_DELAY, 16'h0003);
    wr(LDSC_IDX_LD_SEL, 16'h0000);
    tick_en <= 1;
    cal();
    wait_lock(n);
    chk(n >= 5 && n <= 10, 1'b1);
    chk(n >= 5, 1'b1);
    cal();
    chk(lock, 1'b0);
    wait_lock(n);
    chk(lock, 1'b1);
    // Kind 1 needs the tuning window too
    wr(LDSC_IDX_LD_SEL, 16'h0001);
    cal();
    repeat (20) @(negedge clk);
    chk(lock, 1'b0);
    @(posedge clk);
    vt_set <= 1;
    wait_lock(n);
    chk(n <= 4, 1'b1);
    // Reset command restores what software changed
    wr(LDSC_IDX_SYNC_CFG, 16'hC001);
    wr(LDSC_IDX_RESET, 16'h0002);
    axr(LDSC_IDX_FIXED, d, rs);
    chk(d, 32'h000000A8);
    axr(LDSC_IDX_SYNC_CFG, d, rs);
    chk(d, 32'h00008001);
    axr(LDSC_IDX_LOCK_INDICATOR_DELAY, d, rs);
    chk(d, {16'h0000, LDSC_RST_LOCK_INDICATOR_DELAY});
    wr(LDSC_IDX_LOCK_INDICATOR_DELAY, 16'h0005);
    // Second hard reset in mid-run
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    chk(lock, 1'b0);
    axr(LDSC_IDX_LOCK_INDICATOR_DELAY, d, rs);
    chk(d, 32'h000003E8);
    give_verdict();
  end
endmodule

// ==== rtl/ldsc_input_gate.sv ====
// Input receiver selection and disregard gating for the two phase inputs
`timescale 1ns/1ps
module ldsc_input_gate
  import ldsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic disregard,
  input wire logic phase_en,
  input wire logic [2:0] fmt,
  input wire logic sync_in,
  input wire logic refreq_in,
  output logic sync_lvds,
  output logic refreq_lvds,
  output logic lvds_filter,
  output logic sync_edge,
  output logic refreq_edge
);
  logic sync_d_reg;
  logic ref_d_reg;
  logic block;

  // Ignoring only applies while phase alignment is off
  assign block = disregard && !phase_en;
  // Codes 0 and 4 are both CMOS; bit 2 adds the filter
  assign sync_lvds = fmt[0];
  assign refreq_lvds = fmt[1];
  assign lvds_filter = fmt[2] && (fmt[1:0] != 2'h0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_d_reg <= 1'b0;
      ref_d_reg <= 1'b0;
    end else begin
      sync_d_reg <= sync_in;
      ref_d_reg <= refreq_in;
    end
  end

  assign sync_edge = !block && (sync_in != sync_d_reg);
  assign refreq_edge = !block && (refreq_in != ref_d_reg);

  AST_IGNORE_INPUTS: assert property (@(posedge clk) disable iff (rst)
    block |-> !sync_edge && !refreq_edge)
    else $error("Input transition acted on while disregarded");
  COV_SYNC_EDGE: cover property (@(posedge clk) sync_edge);
endmodule

// ==== rtl/ldsc_lock_timer.sv ====
// Lock indicator delay counter and lock kind selection
`timescale 1ns/1ps
module ldsc_lock_timer
  import ldsc_pkg::*;
#(
  parameter int DLY_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic half_tick,
  input wire logic cal_start,
  input wire logic cal_done,
  input wire logic vtune_ok,
  input wire logic kind,
  input wire logic [DLY_W-1:0] delay,
  output logic lock
);
  typedef enum {LDSC_IDLE, LDSC_WAIT, LDSC_DONE} ldsc_lk_t;
  ldsc_lk_t state_reg;
  logic [DLY_W-1:0] cnt_reg;

  // Count half phase-detector ticks after calibration completes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= LDSC_IDLE;
      cnt_reg <= '0;
    end else if (cal_start) begin
      state_reg <= LDSC_IDLE;
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        LDSC_IDLE: begin
          if (cal_done) begin
            cnt_reg <= delay;
            state_reg <= (delay == '0) ? LDSC_DONE : LDSC_WAIT;
          end
        end
        LDSC_WAIT: begin
          if (half_tick) begin
            cnt_reg <= cnt_reg - 1'b1;
            if (cnt_reg == {{(DLY_W-1){1'b0}}, 1'b1})
              state_reg <= LDSC_DONE;
          end
        end
        LDSC_DONE: begin
        end
      endcase
    end
  end

  // Kind 1 also needs the tuning voltage window
  assign lock = (state_reg == LDSC_DONE) && (!kind || vtune_ok);

  AST_LOCK_LOW_ON_CAL: assert property (@(posedge clk) disable iff (rst)
    cal_start |=> !lock)
    else $error("Lock seen right after calibration start");
  AST_KIND1_NEEDS_VTUNE: assert property (@(posedge clk) disable iff (rst)
    (lock && kind) |-> vtune_ok)
    else $error("Kind 1 lock without tuning window");
  AST_LOCK_AFTER_DONE: assert property (@(posedge clk) disable iff (rst)
    $rose(lock) && !kind |-> state_reg == LDSC_DONE)
    else $error("Lock rose before delay expired");
  AST_COUNT_DOWN: assert property (@(posedge clk) disable iff (rst)
    (state_reg == LDSC_WAIT && half_tick && !cal_start
     && cnt_reg > 1) |=> cnt_reg == $past(cnt_reg) - 1)
    else $error("Delay counter did not step");
  COV_LOCK: cover property (@(posedge clk) $rose(lock));
  COV_WAIT: cover property (@(posedge clk) state_reg == LDSC_WAIT);
endmodule

// ==== rtl/ldsc_pkg.sv ====
// Package: register map, field layout and reset values for lock/sync config
package ldsc_pkg;
  // Register indices (printed offsets are not multiples of four)
  localparam logic [7:0] LDSC_IDX_SYNC_CFG = 8'h3A;
  localparam logic [7:0] LDSC_IDX_LD_SEL = 8'h3B;
  localparam logic [7:0] LDSC_IDX_LOCK_INDICATOR_DELAY = 8'h3C;
  localparam logic [7:0] LDSC_IDX_FIXED = 8'h3D;
  localparam logic [7:0] LDSC_IDX_BUF_CTL = 8'h3E;
  localparam logic [7:0] LDSC_IDX_RESET = 8'h00;
  localparam logic [7:0] LDSC_IDX_STATUS = 8'h50;
  localparam logic [7:0] LDSC_IDX_MASK = 8'h51;
  localparam logic [7:0] LDSC_IDX_CTRL = 8'h52;
  // Byte address width
  localparam int LDSC_AW = 10;
  // Reset values
  localparam logic [15:0] LDSC_RST_SYNC_CFG = 16'h8001;
  localparam logic [15:0] LDSC_RST_LD_SEL = 16'h0001;
  localparam logic [15:0] LDSC_RST_LOCK_INDICATOR_DELAY = 16'h03E8;
  localparam logic [15:0] LDSC_RST_FIXED = 16'h00A8;
  localparam logic [15:0] LDSC_RST_BUF_CTL = 16'h00AF;
  // Field positions in the sync input configuration, lock kind select and reset command registers
  localparam int LDSC_DISREGARD_BIT = 15;
  localparam int LDSC_HYST_BIT = 14;
  localparam int LDSC_LVL_HI = 13;
  localparam int LDSC_LVL_LO = 12;
  localparam int LDSC_FMT_HI = 11;
  localparam int LDSC_FMT_LO = 9;
  localparam int LDSC_KIND_BIT = 0;
  localparam int LDSC_RESET_BIT = 1;
  // Control register: bit 0 phase alignment enable
  localparam int LDSC_PHASE_EN_BIT = 0;
  // Event bits: 0 lock rise, 1 lock fall, 2 sync edge, 3 ref-req edge
  localparam int LDSC_NEVT = 4;
  // Bias level encodings
  localparam logic [1:0] LDSC_LVL_QUARTER = 2'h0;
  localparam logic [1:0] LDSC_LVL_FULL = 2'h1;
  localparam logic [1:0] LDSC_LVL_HALF = 2'h2;
  localparam logic [1:0] LDSC_LVL_BAD = 2'h3;
  // AXI response codes
  localparam logic [1:0] LDSC_RESP_OK = 2'h0;
  localparam logic [1:0] LDSC_RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/ldsc_top.sv ====
// Lock-detect and sync-input configuration block with AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module ldsc_top
  import ldsc_pkg::*;
#(
  parameter int DLY_W = 16
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // AXI4-Lite write address
  input wire logic [LDSC_AW-1:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  // AXI4-Lite read address
  input wire logic [LDSC_AW-1:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  // Phase inputs and synthesizer status
  input wire logic SYNC_IN,
  input wire logic REFREQ_IN,
  input wire logic PD_HALF_TICK_IN,
  input wire logic CAL_START_IN,
  input wire logic CAL_DONE_IN,
  input wire logic VTUNE_OK_IN,
  // Receiver configuration
  output logic SYNC_LVDS_OUT,
  output logic REFREQ_LVDS_OUT,
  output logic LVDS_FILTER_OUT,
  output logic HIGH_HYST_OUT,
  output logic [1:0] BIAS_LEVEL_OUT,
  output logic BIAS_INVALID_OUT,
  // Events and lock
  output logic SYNC_EVENT_OUT,
  output logic REFREQ_EVENT_OUT,
  output logic LOCK_OUT,
  output logic IRQ_OUT
);
  logic [15:0] sync_cfg_reg;
  logic [15:0] ld_sel_reg;
  logic [15:0] lock_indicator_delay_reg;
  logic [15:0] fixed_reg;
  logic [15:0] buf_ctl_reg;
  logic [15:0] ctrl_reg;
  logic [LDSC_NEVT-1:0] status_reg;
  logic [LDSC_NEVT-1:0] mask_reg;
  logic [LDSC_NEVT-1:0] status_next;
  logic [LDSC_NEVT-1:0] evt;
  logic lock_reg;
  logic lock_now;
  logic sync_edge;
  logic ref_edge;
  logic soft_rst;

  // Write channel state
  logic aw_have_reg;
  logic w_have_reg;
  logic [LDSC_AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic wr_hit;
  logic [15:0] wr_val;

  // Read channel state
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rd_idx;
  logic rd_hit;
  logic [15:0] rd_val;

  // Address handshake: accept each channel while it is not already held and no response is pending
  assign S_AXI_AWREADY_OUT = !aw_have_reg && !bvalid_reg;
  assign S_AXI_WREADY_OUT = !w_have_reg && !bvalid_reg;
  assign S_AXI_BVALID_OUT = bvalid_reg;
  assign S_AXI_BRESP_OUT = bresp_reg;
  assign S_AXI_ARREADY_OUT = !rvalid_reg;
  assign S_AXI_RVALID_OUT = rvalid_reg;
  assign S_AXI_RDATA_OUT = rdata_reg;
  assign S_AXI_RRESP_OUT = rresp_reg;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
      aw_have_reg <= 1'b1;
      awaddr_reg <= S_AXI_AWADDR_IN;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      w_have_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end else if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
      w_have_reg <= 1'b1;
      wdata_reg <= S_AXI_WDATA_IN;
      wstrb_reg <= S_AXI_WSTRB_IN;
    end
  end

  assign wr_fire = aw_have_reg && w_have_reg;
  assign wr_idx = awaddr_reg[LDSC_AW-1:2];
  // Byte lanes 0 and 1 carry the 16-bit registers
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  always_comb begin
    unique case (wr_idx)
      LDSC_IDX_SYNC_CFG, LDSC_IDX_LD_SEL, LDSC_IDX_LOCK_INDICATOR_DELAY, LDSC_IDX_FIXED,
      LDSC_IDX_BUF_CTL, LDSC_IDX_RESET, LDSC_IDX_STATUS, LDSC_IDX_MASK,
      LDSC_IDX_CTRL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= LDSC_RESP_OK;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? LDSC_RESP_OK : LDSC_RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Reset command restores every configuration register
  assign soft_rst = wr_fire && wr_idx == LDSC_IDX_RESET &&
                    wstrb_reg[0] && wdata_reg[LDSC_RESET_BIT];

  // Configuration registers, stored as written; software keeps fixed bits
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sync_cfg_reg <= LDSC_RST_SYNC_CFG;
      ld_sel_reg <= LDSC_RST_LD_SEL;
      lock_indicator_delay_reg <= LDSC_RST_LOCK_INDICATOR_DELAY;
      fixed_reg <= LDSC_RST_FIXED;
      buf_ctl_reg <= LDSC_RST_BUF_CTL;
      ctrl_reg <= '0;
      mask_reg <= '0;
    end else if (soft_rst) begin
      sync_cfg_reg <= LDSC_RST_SYNC_CFG;
      ld_sel_reg <= LDSC_RST_LD_SEL;
      lock_indicator_delay_reg <= LDSC_RST_LOCK_INDICATOR_DELAY;
      fixed_reg <= LDSC_RST_FIXED;
      buf_ctl_reg <= LDSC_RST_BUF_CTL;
      ctrl_reg <= '0;
      mask_reg <= '0;
    end else if (wr_fire) begin
      unique case (wr_idx)
        LDSC_IDX_SYNC_CFG:
          sync_cfg_reg <= merge(sync_cfg_reg, wdata_reg, wstrb_reg);
        LDSC_IDX_LD_SEL:
          ld_sel_reg <= merge(ld_sel_reg, wdata_reg, wstrb_reg);
        LDSC_IDX_LOCK_INDICATOR_DELAY:
          lock_indicator_delay_reg <= merge(lock_indicator_delay_reg, wdata_reg, wstrb_reg);
        LDSC_IDX_FIXED:
          fixed_reg <= merge(fixed_reg, wdata_reg, wstrb_reg);
        LDSC_IDX_BUF_CTL:
          buf_ctl_reg <= merge(buf_ctl_reg, wdata_reg, wstrb_reg);
        LDSC_IDX_CTRL:
          ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
        LDSC_IDX_MASK:
          mask_reg <= wr_val[LDSC_NEVT-1:0];
        default: begin
        end
      endcase
    end
  end
  assign wr_val = merge(16'h0000, wdata_reg, wstrb_reg);

  // Sticky event flags; a new event wins over a write-one clear
  assign evt = {ref_edge, sync_edge, lock_reg && !lock_now,
                !lock_reg && lock_now};
  always_comb begin
    status_next = status_reg;
    if (wr_fire && wr_idx == LDSC_IDX_STATUS)
      status_next = status_next & ~wr_val[LDSC_NEVT-1:0];
    status_next = status_next | evt;
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      status_reg <= '0;
      lock_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      lock_reg <= lock_now;
    end
  end

  assign IRQ_OUT = |(status_reg & mask_reg);

  // Read path
  assign rd_idx = S_AXI_ARADDR_IN[LDSC_AW-1:2];
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    unique case (rd_idx)
      LDSC_IDX_SYNC_CFG: rd_val = sync_cfg_reg;
      LDSC_IDX_LD_SEL: rd_val = ld_sel_reg;
      LDSC_IDX_LOCK_INDICATOR_DELAY: rd_val = lock_indicator_delay_reg;
      LDSC_IDX_FIXED: rd_val = fixed_reg;
      LDSC_IDX_BUF_CTL: rd_val = buf_ctl_reg;
      LDSC_IDX_RESET: rd_val = 16'h0000;
      LDSC_IDX_STATUS: rd_val = {{(16-LDSC_NEVT){1'b0}}, status_reg};
      LDSC_IDX_MASK: rd_val = {{(16-LDSC_NEVT){1'b0}}, mask_reg};
      LDSC_IDX_CTRL: rd_val = {ctrl_reg[15:2], lock_reg,
                               ctrl_reg[LDSC_PHASE_EN_BIT]};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= LDSC_RESP_OK;
    end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {16'h0000, rd_val};
      rresp_reg <= rd_hit ? LDSC_RESP_OK : LDSC_RESP_SLVERR;
    end else if (S_AXI_RREADY_IN) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Receiver configuration outputs
  assign HIGH_HYST_OUT = sync_cfg_reg[LDSC_HYST_BIT];
  assign BIAS_LEVEL_OUT = sync_cfg_reg[LDSC_LVL_HI:LDSC_LVL_LO];
  // Code 3 is flagged, not acted on
  assign BIAS_INVALID_OUT = BIAS_LEVEL_OUT == LDSC_LVL_BAD;

  ldsc_input_gate u_gate (
    .clk(CLK_IN),
    .rst(RST_IN),
    .disregard(sync_cfg_reg[LDSC_DISREGARD_BIT]),
    .phase_en(ctrl_reg[LDSC_PHASE_EN_BIT]),
    .fmt(sync_cfg_reg[LDSC_FMT_HI:LDSC_FMT_LO]),
    .sync_in(SYNC_IN),
    .refreq_in(REFREQ_IN),
    .sync_lvds(SYNC_LVDS_OUT),
    .refreq_lvds(REFREQ_LVDS_OUT),
    .lvds_filter(LVDS_FILTER_OUT),
    .sync_edge(sync_edge),
    .refreq_edge(ref_edge)
  );
  assign SYNC_EVENT_OUT = sync_edge;
  assign REFREQ_EVENT_OUT = ref_edge;

  ldsc_lock_timer #(.DLY_W(DLY_W)) u_lock (
    .clk(CLK_IN),
    .rst(RST_IN),
    .half_tick(PD_HALF_TICK_IN),
    .cal_start(CAL_START_IN),
    .cal_done(CAL_DONE_IN),
    .vtune_ok(VTUNE_OK_IN),
    .kind(ld_sel_reg[LDSC_KIND_BIT]),
    .delay(lock_indicator_delay_reg[DLY_W-1:0]),
    .lock(lock_now)
  );
  assign LOCK_OUT = lock_reg;

  AST_STICKY_SET_WINS: assert property (@(posedge CLK_IN)
    disable iff (RST_IN) evt[2] |=> status_reg[2])
    else $error("Sync event lost");
  AST_IRQ_LEVEL: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    |(status_reg & mask_reg) |-> IRQ_OUT)
    else $error("Interrupt not raised");
  AST_RESET_FIXED: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    soft_rst |=> fixed_reg == LDSC_RST_FIXED)
    else $error("Fixed register not restored");
  AST_HYST_FOLLOWS: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    HIGH_HYST_OUT == sync_cfg_reg[14])
    else $error("Hysteresis output mismatch");
  AST_FMT_CMOS: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    sync_cfg_reg[10:9] == 2'h0 |-> !SYNC_LVDS_OUT && !REFREQ_LVDS_OUT
    && !LVDS_FILTER_OUT)
    else $error("CMOS format drives LVDS");
  AST_WRITE_RESP: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    wr_fire |=> S_AXI_BVALID_OUT)
    else $error("Write response late");
  // Bus answers stand until the master takes them
  AST_READ_RESP: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
    else $error("Read response late");
  AST_BVALID_HOLD: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
    S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
    else $error("Write response dropped early");
  AST_RVALID_HOLD: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
    S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
    else $error("Read data dropped early");
  // Registered lock trails the timer by one cycle
  AST_LOCK_ONE_LATE: assert property (@(posedge CLK_IN)
    disable iff (RST_IN) LOCK_OUT == $past(lock_now))
    else $error("Lock output not one cycle behind timer");
  AST_STATUS_CLEAR: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    wr_fire && wr_idx == LDSC_IDX_STATUS && wr_val[2] && !evt[2] |=>
    !status_reg[2])
    else $error("Write-one clear ignored");
  AST_SOFT_RST_IRQ: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    soft_rst |=> !IRQ_OUT)
    else $error("Interrupt left on after reset command");
  COV_IRQ: cover property (@(posedge CLK_IN) $rose(IRQ_OUT));
  COV_SOFT_RST: cover property (@(posedge CLK_IN) soft_rst);
endmodule
